// ==== src/rsf_pkg.sv ====
/*
  rsf_pkg: constants for the reset state and flag logic.
  assumes: single 20 MHz clock domain, no software register bus.
*/
package rsf_pkg;
  localparam int unsigned PC_W = 13;
  localparam int unsigned SP_W = 4;
  localparam int unsigned IRQ_W = 16;
  localparam int unsigned TMR_W = 4;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned LVS_W = 8;
  localparam int unsigned WDG_W = 16;
  localparam int unsigned TB_W = 16;
  // reset values
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [SP_W-1:0] SP_RST = 4'h0;
  localparam logic [LVS_W-1:0] LVS_POR = 8'h0066;
  localparam logic [PORT_W-1:0] DIR_INPUT = 8'h00ff;
  // cause encoding used by the state machine
  typedef enum logic [2:0] {
    RSF_NONE, RSF_POR, RSF_PIN, RSF_LVR, RSF_WDG_RUN, RSF_WDG_IDLE
  } rsf_cause_e;
endpackage

// ==== src/rsf_reset_ctrl.sv ====
/*
  rsf_reset_ctrl: picks the winning reset source each cycle and applies
  its effect on the reset flags and on the core's initial state.
  assumes: reset requests are level pulses from outside the clock domain;
  the core reports idle/sleep and watchdog/timebase live values itself.
*/
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - idle watchdog expiry: clear pc/sp, set timeout
// - power-on clears flags; pin/lvr keep them
// - run watchdog expiry sets timeout, keeps powerdown
// - idle watchdog expiry sets both flags
// - power-on: pc zero, interrupts disabled
// - power-on clears watchdog, timebases; watchdog restarts
// - power-on turns timer modules off
// - power-on makes all port pins inputs
// - power-on points stack at top
// - genuine low-voltage reset keeps threshold select
module rsf_reset_ctrl #(
  parameter int unsigned PC_W = rsf_pkg::PC_W,
  parameter int unsigned SP_W = rsf_pkg::SP_W,
  parameter int unsigned IRQ_W = rsf_pkg::IRQ_W,
  parameter int unsigned TMR_W = rsf_pkg::TMR_W,
  parameter int unsigned PORT_W = rsf_pkg::PORT_W,
  parameter int unsigned LVS_W = rsf_pkg::LVS_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // reset sources, asynchronous levels
  input wire logic power_on_req,
  input wire logic external_reset_pin,
  input wire logic low_voltage_reset,
  input wire logic watchdog_expired,
  // core status, same clock
  input wire logic core_idle,
  input wire logic power_down_set,
  input wire logic flags_clear,
  input wire logic lvs_wr,
  input wire logic [LVS_W-1:0] lvs_wdata,
  // flags
  output logic timeout_flag,
  output logic power_down_flag,
  // state applied to the core
  output logic core_reset,
  output logic warm_wake,
  output logic [PC_W-1:0] pc_init,
  output logic [SP_W-1:0] sp_init,
  output logic irq_enable_clr,
  output logic watchdog_counter_clr,
  output logic timebase_clr,
  output logic [TMR_W-1:0] timer_enable,
  output logic [PORT_W-1:0] port_dir,
  output logic [LVS_W-1:0] low_voltage_threshold_select,
  output logic [2:0] last_cause
);

  //////////////////////////////////////////////////////////////////////
  // synchronise the external sources
  logic [3:0] req_s;
  logic por_s, pin_s, lvr_s, wdg_s;

  rsf_sync #(.W(4)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({power_on_req, external_reset_pin, low_voltage_reset,
               watchdog_expired}),
    .sync_out(req_s)
  );
  assign {por_s, pin_s, lvr_s, wdg_s} = req_s;

  // rising edges only, so a held source resets once
  logic [3:0] req_prev_q;
  logic [3:0] req_prev_d;
  logic [3:0] req_rise;
  assign req_rise = req_s & ~req_prev_q;

  //////////////////////////////////////////////////////////////////////
  // pick of the cause; several at once act as power-on, the fullest init
  function automatic rsf_pkg::rsf_cause_e pick_cause(
      input logic [3:0] rise, input logic idle);
    if (rise[3] || $countones(rise) > 1) begin
      pick_cause = rsf_pkg::RSF_POR;
    end else if (rise[2]) begin
      pick_cause = rsf_pkg::RSF_PIN;
    end else if (rise[1]) begin
      pick_cause = rsf_pkg::RSF_LVR;
    end else if (rise[0]) begin
      pick_cause = idle ? rsf_pkg::RSF_WDG_IDLE : rsf_pkg::RSF_WDG_RUN;
    end else begin
      pick_cause = rsf_pkg::RSF_NONE;
    end
  endfunction

  rsf_pkg::rsf_cause_e cause;
  assign cause = pick_cause(req_rise, core_idle);

  //////////////////////////////////////////////////////////////////////
  // flag and state registers
  logic to_q, to_d, pd_q, pd_d;
  logic core_rst_q, core_rst_d, wake_q, wake_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic irq_clr_q, irq_clr_d, wdg_clr_q, wdg_clr_d, tb_clr_q, tb_clr_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [PORT_W-1:0] dir_q, dir_d;
  logic [LVS_W-1:0] lvs_q, lvs_d;
  logic [2:0] cause_q, cause_d;

  // next-state: a reset event wins over software clears
  always_comb begin
    to_d = to_q;
    pd_d = pd_q;
    if (flags_clear) begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end
    if (power_down_set) begin
      pd_d = 1'b1;
    end
    core_rst_d = 1'b0;
    wake_d = 1'b0;
    pc_d = pc_q;
    sp_d = sp_q;
    irq_clr_d = 1'b0;
    wdg_clr_d = 1'b0;
    tb_clr_d = 1'b0;
    tmr_d = tmr_q;
    dir_d = dir_q;
    lvs_d = lvs_wr ? lvs_wdata : lvs_q;
    req_prev_d = req_s;
    cause_d = (cause == rsf_pkg::RSF_NONE) ? cause_q : 3'(cause);
    unique case (cause)
      rsf_pkg::RSF_POR: begin
        to_d = 1'b0;
        pd_d = 1'b0;
        core_rst_d = 1'b1;
        pc_d = rsf_pkg::PC_RST;
        irq_clr_d = 1'b1;
        wdg_clr_d = 1'b1;
        tb_clr_d = 1'b1;
        tmr_d = '0;
        dir_d = rsf_pkg::DIR_INPUT;
        sp_d = rsf_pkg::SP_RST;
        lvs_d = rsf_pkg::LVS_POR;
      end
      rsf_pkg::RSF_PIN, rsf_pkg::RSF_LVR: begin
        // flags untouched here
        core_rst_d = 1'b1;
        pc_d = rsf_pkg::PC_RST;
        sp_d = rsf_pkg::SP_RST;
        irq_clr_d = 1'b1;
        wdg_clr_d = 1'b1;
        tb_clr_d = 1'b1;
        tmr_d = '0;
        dir_d = rsf_pkg::DIR_INPUT;
        // threshold survives a genuine low supply
        if (cause == rsf_pkg::RSF_PIN) begin
          lvs_d = rsf_pkg::LVS_POR;
        end else begin
          lvs_d = lvs_q;
        end
      end
      rsf_pkg::RSF_WDG_RUN: begin
        to_d = 1'b1;
        pd_d = pd_q;
        core_rst_d = 1'b1;
        pc_d = rsf_pkg::PC_RST;
        sp_d = rsf_pkg::SP_RST;
        irq_clr_d = 1'b1;
        wdg_clr_d = 1'b1;
        tb_clr_d = 1'b1;
        tmr_d = '0;
        dir_d = rsf_pkg::DIR_INPUT;
        lvs_d = rsf_pkg::LVS_POR;
      end
      rsf_pkg::RSF_WDG_IDLE: begin
        // warm reset: pc, sp, both flags and last cause move, rest kept
        to_d = 1'b1;
        pd_d = 1'b1;
        wake_d = 1'b1;
        pc_d = rsf_pkg::PC_RST;
        sp_d = rsf_pkg::SP_RST;
      end
      rsf_pkg::RSF_NONE: begin
      end
    endcase
  end

  // registers; reset state equals power-on state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      to_q <= 1'b0;
      pd_q <= 1'b0;
      core_rst_q <= 1'b1;
      wake_q <= 1'b0;
      pc_q <= rsf_pkg::PC_RST;
      sp_q <= rsf_pkg::SP_RST;
      irq_clr_q <= 1'b1;
      wdg_clr_q <= 1'b1;
      tb_clr_q <= 1'b1;
      tmr_q <= '0;
      dir_q <= rsf_pkg::DIR_INPUT;
      lvs_q <= rsf_pkg::LVS_POR;
      req_prev_q <= 4'h0;
      cause_q <= 3'(rsf_pkg::RSF_POR);
    end else begin
      to_q <= to_d;
      pd_q <= pd_d;
      core_rst_q <= core_rst_d;
      wake_q <= wake_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      irq_clr_q <= irq_clr_d;
      wdg_clr_q <= wdg_clr_d;
      tb_clr_q <= tb_clr_d;
      tmr_q <= tmr_d;
      dir_q <= dir_d;
      lvs_q <= lvs_d;
      req_prev_q <= req_prev_d;
      cause_q <= cause_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign timeout_flag = to_q;
  assign power_down_flag = pd_q;
  assign core_reset = core_rst_q;
  assign warm_wake = wake_q;
  assign pc_init = pc_q;
  assign sp_init = sp_q;
  assign irq_enable_clr = irq_clr_q;
  assign watchdog_counter_clr = wdg_clr_q; // counts again next cycle
  assign timebase_clr = tb_clr_q;
  assign timer_enable = tmr_q;
  assign port_dir = dir_q;
  assign low_voltage_threshold_select = lvs_q;
  assign last_cause = cause_q;
endmodule

// ==== src/rsf_sync.sv ====
/*
  rsf_sync: two-flop synchroniser for asynchronous reset sources.
  assumes: inputs are levels held for several clock cycles.
*/
`timescale 1ns/1ps
module rsf_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== verification/reset_state_and_flag_logic_tb_top.sv ====
/* testbench: random reset events against an integer reference model.
   assumes: rsf_reset_ctrl with default widths, inputs driven at negedge. */
`timescale 1ns/1ps
module reset_state_and_flag_logic_tb_top;
  logic clock = 0, rst_n = 0, core_idle = 0, power_down_set = 0;
  logic flags_clear = 0, lvs_wr = 0, cold, hung = 0;
  logic [3:0] src = 0; // por, pin, lvr, watchdog
  logic [7:0] lvs_wdata = 8'h00;
  logic timeout_flag, power_down_flag, core_reset, warm_wake;
  logic irq_enable_clr, watchdog_counter_clr, timebase_clr;
  logic [12:0] pc_init;
  logic [3:0] sp_init, timer_enable;
  logic [7:0] port_dir, low_voltage_threshold_select;
  logic [2:0] last_cause;
  int failures = 0, n_checks = 0, seed = 65632, to, pd, lvs, cause, k;
  always #25 clock = ~clock;
  rsf_reset_ctrl dut (.clock, .rst_n, .power_on_req(src[0]),
    .external_reset_pin(src[1]), .low_voltage_reset(src[2]),
    .watchdog_expired(src[3]), .core_idle, .power_down_set, .flags_clear,
    .lvs_wr, .lvs_wdata, .timeout_flag, .power_down_flag, .core_reset,
    .warm_wake, .pc_init, .sp_init, .irq_enable_clr, .watchdog_counter_clr,
    .timebase_clr, .timer_enable, .port_dir,
    .low_voltage_threshold_select, .last_cause);
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("Error t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // levels that must match the model after every event
  task state;
    chk(timeout_flag, 16'(to));
    chk(power_down_flag, 16'(pd));
    chk(low_voltage_threshold_select, 16'(lvs));
    chk(last_cause, 16'(cause));
    chk({3'b000, pc_init}, 16'h0000);
    chk({12'h000, sp_init}, 16'h0000);
    chk({timer_enable, port_dir}, 16'h00ff);
  endtask
  // one event; simultaneous sources act as power-on
  task ev(input logic [3:0] s, input logic idle);
    @(negedge clock);
    src = s;
    core_idle = idle;
    cold = s[2:0] != 0 || !idle;
    if (s[0] || $countones(s) > 1) begin
      to = 0;
      pd = 0;
      lvs = 'h66;
      cause = 1;
    end
    else if (s[1]) begin lvs = 'h66; cause = 2; end
    else if (s[2]) cause = 3;
    else if (idle) begin to = 1; pd = 1; cause = 5; end
    else begin to = 1; lvs = 'h66; cause = 4; end
    k = 0;
    while ((core_reset | warm_wake) !== 1'b1 && k < 8) begin
      @(negedge clock);
      k++;
    end
    // a hang counts once here; the main loop then stops
    if (k == 8) begin
      failures++;
      hung = 1;
    end
    chk({core_reset, warm_wake}, {cold, !cold});
    chk({irq_enable_clr, watchdog_counter_clr, timebase_clr},
      cold ? 16'h0007 : 16'h0000);
    state;
    @(negedge clock);
    src = 0;
    core_idle = 0;
    chk({core_reset, warm_wake, irq_enable_clr, watchdog_counter_clr,
      timebase_clr}, 16'h0000);
    repeat (3) @(negedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] s;
    to = 0; pd = 0; lvs = 'h66; cause = 1;
    repeat (16) @(negedge clock);
    rst_n = 1;
    state;
    for (int i = 0; i < 40 && !hung; i++) begin
      @(negedge clock);
      {power_down_set, flags_clear, lvs_wr} = 3'($random(seed));
      lvs_wdata = 8'($random(seed));
      if (flags_clear) begin to = 0; pd = 0; end
      if (power_down_set) pd = 1; // set beats clear
      if (lvs_wr) lvs = lvs_wdata;
      @(negedge clock);
      {power_down_set, flags_clear, lvs_wr} = 3'b000;
      state;
      s = i < 4 ? 4'h1 << i : 4'($random(seed));
      if (s == 0 || i == 4) s = 4'h8;
      ev(s, s == 8 && (i == 4 || 1'($random(seed))));
    end
    test_done;
  end
endmodule

// ==== verification/rsf_reset_props.sv ====
/* rsf_reset_props: port-level properties of the reset controller.
   assumes: bound to rsf_reset_ctrl, one clock domain. */
`timescale 1ns/1ps
module rsf_reset_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched
  input wire logic power_on_req,
  input wire logic timeout_flag,
  input wire logic power_down_flag,
  input wire logic core_reset,
  input wire logic warm_wake,
  input wire logic [12:0] pc_init,
  input wire logic [3:0] sp_init,
  input wire logic irq_enable_clr,
  input wire logic watchdog_counter_clr,
  input wire logic timebase_clr,
  input wire logic [3:0] timer_enable,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] low_voltage_threshold_select,
  input wire logic [2:0] last_cause
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // warm wake touches only pc, sp, flags and last cause
  a_wake_state: assert property (warm_wake |-> pc_init == 0 && sp_init == 0
    && timeout_flag && $stable(port_dir)) else $error("warm wake state");
  a_idle_flags: assert property (warm_wake |-> power_down_flag)
    else $error("idle flags");
  a_wake_once: assert property (warm_wake |=> !warm_wake)
    else $error("wake pulse long");
  // sync plus edge detect gives three or four sampled edges
  a_por_flags: assert property ($rose(power_on_req) |-> ##[3:4]
    (core_reset && last_cause == 3'h1 && !timeout_flag && !power_down_flag))
    else $error("power-on flags");
  a_run_wdg: assert property (core_reset && last_cause == 3'h4
    |-> timeout_flag) else $error("run watchdog flag");
  a_cold_clrs: assert property (core_reset |-> irq_enable_clr
    && watchdog_counter_clr && timebase_clr) else $error("cold clears");
  a_cold_io: assert property (core_reset |-> timer_enable == 4'h0
    && port_dir == 8'hff) else $error("cold io");
  a_por_init: assert property (core_reset && last_cause == 3'h1
    |-> pc_init == 0 && sp_init == 0 && low_voltage_threshold_select == 8'h66)
    else $error("power-on init");
  a_lvr_keep: assert property (core_reset && last_cause == 3'h3
    |-> $stable(low_voltage_threshold_select)) else $error("lvr threshold");
endmodule
//////////////////////////////////////////////////////////////////////////
bind rsf_reset_ctrl rsf_reset_props u_props (.clock, .rst_n, .power_on_req,
  .timeout_flag, .power_down_flag, .core_reset, .warm_wake, .pc_init,
  .sp_init, .irq_enable_clr, .watchdog_counter_clr, .timebase_clr,
  .timer_enable, .port_dir, .low_voltage_threshold_select, .last_cause);
